// [line_encoder_pkg.sv]
`default_nettype none
package line_encoder_pkg;

	// parallel word from the fabric, one per transmit clock
	typedef struct packed {
		logic [7:0] data;
		logic       ctrl_en;
		logic       force_disp;
		logic       disp_val;
	} tx_word_t;

	typedef enum logic [1:0] {
		ST_RESET = 2'h0,
		ST_FILL  = 2'h1,
		ST_SYNC  = 2'h3,
		ST_DATA  = 2'h2
	} enc_state_t;

	// running disparity encoding: 1 is positive
	localparam logic       RD_NEG        = 1'h0;
	localparam logic       RD_POS        = 1'h1;
	// code group bit 9 is line bit a, bit 0 is line bit j
	localparam logic [7:0] K28_5_BYTE    = 8'hbc;
	localparam logic [9:0] K28_5_NEG     = 10'h0fa;
	localparam logic [9:0] K28_5_POS     = 10'h305;
	localparam logic [4:0] K28_X         = 5'h1c;
	localparam logic [5:0] K28_SIX_NEG   = 6'h0f;
	localparam logic [1:0] FILL_WORDS    = 2'h2;
	localparam logic [1:0] SYNC_WORDS    = 2'h3;
	localparam logic [1:0] COUNT_RESET   = 2'h0;
	localparam logic [9:0] CODE_RESET    = K28_5_NEG;

endpackage : line_encoder_pkg
`default_nettype wire

// [code_group_mapper.sv]
`timescale 1ns/100ps
`default_nettype none
module code_group_mapper (
	input  wire logic [7:0] data,
	input  wire logic       ctrl_en,
	input  wire logic       rd_in,
	output logic      [9:0] code,
	output logic            rd_out
);
	logic [4:0] x;
	logic [2:0] y;
	logic [5:0] six_raw;
	logic [5:0] six;
	logic [3:0] four_raw;
	logic [3:0] four;
	logic [3:0] k_four;
	logic       six_unbal;
	logic       four_unbal;
	logic       rd_mid;
	logic       alt7;
	logic [9:0] k_neg;
	int         ones;

	always_comb begin
		x = data[4:0];
		y = data[7:5];
		case (x)
			5'h00: six_raw = 6'h27;
			5'h01: six_raw = 6'h1d;
			5'h02: six_raw = 6'h2d;
			5'h03: six_raw = 6'h31;
			5'h04: six_raw = 6'h35;
			5'h05: six_raw = 6'h29;
			5'h06: six_raw = 6'h19;
			5'h07: six_raw = 6'h38;
			5'h08: six_raw = 6'h39;
			5'h09: six_raw = 6'h25;
			5'h0a: six_raw = 6'h15;
			5'h0b: six_raw = 6'h34;
			5'h0c: six_raw = 6'h0d;
			5'h0d: six_raw = 6'h2c;
			5'h0e: six_raw = 6'h1c;
			5'h0f: six_raw = 6'h17;
			5'h10: six_raw = 6'h1b;
			5'h11: six_raw = 6'h23;
			5'h12: six_raw = 6'h13;
			5'h13: six_raw = 6'h32;
			5'h14: six_raw = 6'h0b;
			5'h15: six_raw = 6'h2a;
			5'h16: six_raw = 6'h1a;
			5'h17: six_raw = 6'h3a;
			5'h18: six_raw = 6'h33;
			5'h19: six_raw = 6'h26;
			5'h1a: six_raw = 6'h16;
			5'h1b: six_raw = 6'h36;
			5'h1c: six_raw = 6'h0e;
			5'h1d: six_raw = 6'h2e;
			5'h1e: six_raw = 6'h1e;
			default: six_raw = 6'h2b;
		endcase
		six_unbal = ($countones(six_raw) != 3);
		six = (rd_in && (six_unbal || x == 5'h07)) ? ~six_raw : six_raw;
		rd_mid = rd_in ^ six_unbal;
		alt7 = ctrl_en
			|| (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e));
		case (y)
			3'h0: four_raw = 4'hb;
			3'h1: four_raw = 4'h9;
			3'h2: four_raw = 4'h5;
			3'h3: four_raw = 4'hc;
			3'h4: four_raw = 4'hd;
			3'h5: four_raw = 4'ha;
			3'h6: four_raw = 4'h6;
			default: four_raw = alt7 ? 4'h7 : 4'he;
		endcase
		four_unbal = ($countones(four_raw) != 2);
		four = (rd_mid && (four_unbal || y == 3'h3)) ? ~four_raw : four_raw;
		case (y)
			3'h0: k_four = 4'h4;
			3'h1: k_four = 4'h9;
			3'h2: k_four = 4'h5;
			3'h3: k_four = 4'h3;
			3'h4: k_four = 4'h2;
			3'h5: k_four = 4'ha;
			3'h6: k_four = 4'h6;
			default: k_four = 4'h8;
		endcase
		// k28 groups: positive form is the full complement
		k_neg = {line_encoder_pkg::K28_SIX_NEG, k_four};
		if (ctrl_en && x == line_encoder_pkg::K28_X) begin
			code = rd_in ? ~k_neg : k_neg;
		end else begin
			code = {six, four};
		end
		// disparity follows the group actually sent
		ones = $countones(code);
		rd_out = (ones == 5) ? rd_in : (ones > 5);
	end

endmodule : code_group_mapper
`default_nettype wire

// [line_encoder_reset_disparity.sv]
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// [RQ1] while reset is low, fabric data and control flag are ignored
// [RQ2] during reset the output repeats K28.5 in its negative disparity form
// [RQ3] running disparity starts negative when reset is released
// [RQ4] after release exactly three K28.5 groups precede fabric data
// [RQ5] filler words from pipeline latency come before the three K28.5
// [RQ6] fabric may force disparity via force and value inputs with the word
// [RQ7] unforced, running disparity makes repeated K28.5 alternate forms
// [RQ8] when force is high the group uses the chosen disparity
// [RQ9] value low means positive, high negative; disparity updates from sent group
module line_encoder_reset_disparity (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	input  wire line_encoder_pkg::tx_word_t  tx_word,
	output logic                      [9:0]  code_q,
	output logic                             rd_q,
	output logic                             data_phase_q
);
	line_encoder_pkg::enc_state_t state_q;
	line_encoder_pkg::enc_state_t state_d;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic [9:0] code_d;
	logic       rd_d;
	logic       data_phase_d;
	logic [7:0] map_data;
	logic       map_ctrl;
	logic       map_rd;
	logic [9:0] map_code;
	logic       map_rd_out;

	code_group_mapper u_mapper (
		.data    (map_data),
		.ctrl_en (map_ctrl),
		.rd_in   (map_rd),
		.code    (map_code),
		.rd_out  (map_rd_out)
	);

	// sequence control
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			line_encoder_pkg::ST_RESET: begin
				state_d = line_encoder_pkg::ST_FILL;
				cnt_d = line_encoder_pkg::COUNT_RESET;
			end
			line_encoder_pkg::ST_FILL: begin
				// pipeline filler words ahead of sync, see [RQ5]
				if (cnt_q == line_encoder_pkg::FILL_WORDS - 2'h1) begin
					state_d = line_encoder_pkg::ST_SYNC;
					cnt_d = line_encoder_pkg::COUNT_RESET;
				end else begin
					cnt_d = cnt_q + 2'h1;
				end
			end
			line_encoder_pkg::ST_SYNC: begin
				// three sync groups then data, see [RQ4]
				if (cnt_q == line_encoder_pkg::SYNC_WORDS - 2'h1) begin
					state_d = line_encoder_pkg::ST_DATA;
					cnt_d = line_encoder_pkg::COUNT_RESET;
				end else begin
					cnt_d = cnt_q + 2'h1;
				end
			end
			default: begin
				state_d = line_encoder_pkg::ST_DATA;
				cnt_d = line_encoder_pkg::COUNT_RESET;
			end
		endcase
	end

	// code group selection
	always_comb begin
		map_data = line_encoder_pkg::K28_5_BYTE;
		map_ctrl = 1'h1;
		map_rd = rd_q;
		code_d = line_encoder_pkg::K28_5_NEG;
		rd_d = line_encoder_pkg::RD_NEG;
		data_phase_d = 1'h0;
		case (state_q)
			line_encoder_pkg::ST_SYNC: begin
				code_d = map_code;
				rd_d = map_rd_out;
			end
			line_encoder_pkg::ST_DATA: begin
				map_data = tx_word.data;
				map_ctrl = tx_word.ctrl_en;
				if (tx_word.force_disp) begin
					// low picks positive, high negative, see [RQ8] see [RQ9] see [RQ6]
					map_rd = ~tx_word.disp_val;
				end
				code_d = map_code;
				// disparity from the group sent, see [RQ7] see [RQ9]
				rd_d = map_rd_out;
				data_phase_d = 1'h1;
			end
			default: begin
				code_d = line_encoder_pkg::K28_5_NEG;
				rd_d = line_encoder_pkg::RD_NEG;
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			// fabric inputs unused here, see [RQ1] see [RQ2] see [RQ3]
			state_q <= line_encoder_pkg::ST_RESET;
			cnt_q <= line_encoder_pkg::COUNT_RESET;
			code_q <= line_encoder_pkg::CODE_RESET;
			rd_q <= line_encoder_pkg::RD_NEG;
			data_phase_q <= 1'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			code_q <= code_d;
			rd_q <= rd_d;
			data_phase_q <= data_phase_d;
		end
	end

	chk_reset_comma_out: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ2]
		$rose(rst_n) |-> code_q == line_encoder_pkg::K28_5_NEG
			&& state_q == line_encoder_pkg::ST_RESET)
		else $error("reset output is not negative K28.5");

	chk_inputs_ignored: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ1]
		$rose(rst_n) |-> !data_phase_q && code_q == line_encoder_pkg::K28_5_NEG)
		else $error("fabric input reached output during reset");

	chk_rd_start_neg: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ3]
		$rose(rst_n) |-> ##2 rd_q == line_encoder_pkg::RD_NEG
			&& state_q == line_encoder_pkg::ST_FILL)
		else $error("disparity not negative at start");

	chk_fill_length: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ5]
		$rose(state_q == line_encoder_pkg::ST_FILL) |->
			(state_q == line_encoder_pkg::ST_FILL)[*2] ##1 state_q == line_encoder_pkg::ST_SYNC)
		else $error("filler phase has wrong length");

	chk_sync_groups: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ4]
		$rose(state_q == line_encoder_pkg::ST_SYNC) |->
			##1 code_q == line_encoder_pkg::K28_5_NEG
			##1 code_q == line_encoder_pkg::K28_5_POS
			##1 code_q == line_encoder_pkg::K28_5_NEG && !data_phase_q
			##1 data_phase_q)
		else $error("sync sequence is not three K28.5 groups");

	chk_rd_alternates: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ7]
		(state_q == line_encoder_pkg::ST_DATA && tx_word.ctrl_en && !tx_word.force_disp
			&& tx_word.data == line_encoder_pkg::K28_5_BYTE)
			|=> rd_q != $past(rd_q))
		else $error("K28.5 did not flip running disparity");

	chk_force_pos: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ8]
		(state_q == line_encoder_pkg::ST_DATA && tx_word.force_disp && !tx_word.disp_val
			&& tx_word.ctrl_en && tx_word.data == line_encoder_pkg::K28_5_BYTE)
			|=> code_q == line_encoder_pkg::K28_5_POS && rd_q == line_encoder_pkg::RD_NEG)
		else $error("forced positive K28.5 not sent");

	chk_force_neg: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ9]
		(state_q == line_encoder_pkg::ST_DATA && tx_word.force_disp && tx_word.disp_val
			&& tx_word.ctrl_en && tx_word.data == line_encoder_pkg::K28_5_BYTE)
			|=> code_q == line_encoder_pkg::K28_5_NEG && rd_q == line_encoder_pkg::RD_POS)
		else $error("forced negative K28.5 not sent");

	chk_force_gated: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ6]
		(state_q == line_encoder_pkg::ST_SYNC && cnt_q == 2'h1) |=>
			code_q == line_encoder_pkg::K28_5_POS)
		else $error("force acted outside data phase");

	chk_reset_outputs: assert property (@(posedge clock) // see [RQ1]
		!rst_n |=> code_q == line_encoder_pkg::K28_5_NEG && rd_q == line_encoder_pkg::RD_NEG
			&& !data_phase_q)
		else $error("outputs moved while reset was held");

	chk_reset_to_fill: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ5]
		state_q == line_encoder_pkg::ST_RESET |=> state_q == line_encoder_pkg::ST_FILL)
		else $error("reset state not followed by filler");

	chk_fill_outputs: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ3]
		state_q == line_encoder_pkg::ST_FILL |=> code_q == line_encoder_pkg::K28_5_NEG
			&& rd_q == line_encoder_pkg::RD_NEG && !data_phase_q)
		else $error("filler word changed disparity or output");

	chk_fill_count: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ5]
		state_q == line_encoder_pkg::ST_FILL |-> cnt_q < line_encoder_pkg::FILL_WORDS)
		else $error("filler count out of range");

	chk_sync_count: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ4]
		state_q == line_encoder_pkg::ST_SYNC |-> cnt_q < line_encoder_pkg::SYNC_WORDS)
		else $error("sync count out of range");

	chk_sync_rd_start: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ3]
		$rose(state_q == line_encoder_pkg::ST_SYNC) |-> rd_q == line_encoder_pkg::RD_NEG)
		else $error("first sync group not from negative disparity");

	chk_sync_to_data: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ4]
		(state_q == line_encoder_pkg::ST_SYNC
			&& cnt_q == line_encoder_pkg::SYNC_WORDS - 2'h1)
			|=> state_q == line_encoder_pkg::ST_DATA)
		else $error("data phase not entered after third sync");

	chk_no_early_data: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ4]
		state_q != line_encoder_pkg::ST_DATA |=> !data_phase_q)
		else $error("fabric word sent before data phase");

	chk_data_stays: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ4]
		state_q == line_encoder_pkg::ST_DATA |=> state_q == line_encoder_pkg::ST_DATA
			&& data_phase_q)
		else $error("data phase left without reset");

	chk_rd_after_neg: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ9]
		(data_phase_q && code_q == line_encoder_pkg::K28_5_NEG)
			|-> rd_q == line_encoder_pkg::RD_POS)
		else $error("disparity not positive after negative K28.5");

	chk_rd_after_pos: assert property (@(posedge clock) disable iff (!rst_n) // see [RQ9]
		(data_phase_q && code_q == line_encoder_pkg::K28_5_POS)
			|-> rd_q == line_encoder_pkg::RD_NEG)
		else $error("disparity not negative after positive K28.5");

endmodule : line_encoder_reset_disparity
`default_nettype wire

// [fabric_word_source.sv]
`timescale 1ns/100ps
`default_nettype none
// fabric side: presents one word per call, all flags with the word
module fabric_word_source (
	output var line_encoder_pkg::tx_word_t tx_word
);

	initial begin
		tx_word = '{data: 8'h5a, ctrl_en: 1'h1, force_disp: 1'h1, disp_val: 1'h0};
	end

	// force and value travel alongside the affected byte
	task automatic drive(input logic [7:0] b, input logic c, input logic f, input logic v);
		tx_word = '{data: b, ctrl_en: c, force_disp: f, disp_val: v};
	endtask : drive

endmodule : fabric_word_source
`default_nettype wire

// [line_encoder_reset_disparity_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module line_encoder_reset_disparity_tb;

	logic                       clock;
	logic                       rst_n;
	line_encoder_pkg::tx_word_t tx_word;
	logic [9:0]                 code_q;
	logic                       rd_q;
	logic                       data_phase_q;
	int                         n_mismatch;
	int                         tests_run;
	int                         cycles;
	logic                       rd_m;

	fabric_word_source u_fabric_word_source (.tx_word(tx_word));

	line_encoder_reset_disparity u_line_encoder_reset_disparity (
		.clock       (clock),
		.rst_n       (rst_n),
		.tx_word     (tx_word),
		.code_q      (code_q),
		.rd_q        (rd_q),
		.data_phase_q(data_phase_q)
	);

	initial clock = 1'b0;
	always #25 clock = ~clock;

	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : report_and_stop

	// hang guard
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// drives one word at a falling edge and judges its group at the next
	task automatic push(input logic [7:0] b, input logic c, input logic f, input logic v);
		logic       disp;
		logic [9:0] exp_code;
		disp = f ? ~v : rd_m;
		exp_code = (b == 8'hbc) ? (disp ? 10'h305 : 10'h0fa) : 10'h2aa;
		rd_m = (b == 8'hbc) ? ~disp : disp;
		u_fabric_word_source.drive(b, c, f, v);
		@(negedge clock);
		check("code", code_q, exp_code);
		check("disparity", {9'h0, rd_q}, {9'h0, rd_m});
		check("data phase", {9'h0, data_phase_q}, 10'h001);
	endtask : push

	// reset held while the fabric drives changing junk
	task automatic hold_reset(input int n);
		rst_n = 1'b0;
		for (int k = 0; k < n; k++) begin
			u_fabric_word_source.drive(8'(k * 37), k[0], ~k[0], k[1]);
			@(negedge clock);
			check("reset code", code_q, 10'h0fa);
			check("reset rd", {8'h0, rd_q, data_phase_q}, 10'h000);
		end
	endtask : hold_reset

	// fill words, then exactly three K28.5 starting negative
	task automatic release_sync();
		logic [9:0] sync_code [6];
		logic       sync_rd   [6];
		sync_code = '{10'h0fa, 10'h0fa, 10'h0fa, 10'h0fa, 10'h305, 10'h0fa};
		sync_rd = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
		rst_n = 1'b1;
		for (int k = 0; k < 6; k++) begin
			// force against the natural disparity of each sync group, must be ignored
			u_fabric_word_source.drive(8'hb5, 1'b0, 1'b1, ~k[0]);
			@(negedge clock);
			check("sync code", code_q, sync_code[k]);
			check("sync rd", {8'h0, rd_q, data_phase_q}, {8'h0, sync_rd[k], 1'b0});
		end
		rd_m = 1'b1;
	endtask : release_sync

	task automatic run_alternation();
		repeat (4) push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hb5, 1'b0, 1'b0, 1'b0);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
	endtask : run_alternation

	task automatic run_forcing();
		push(8'hbc, 1'b1, 1'b1, 1'b0);
		push(8'hbc, 1'b1, 1'b1, 1'b0);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hbc, 1'b1, 1'b1, 1'b1);
		push(8'hbc, 1'b1, 1'b1, 1'b1);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hb5, 1'b0, 1'b1, 1'b0);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hb5, 1'b0, 1'b1, 1'b1);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
		push(8'hbc, 1'b1, 1'b0, 1'b0);
	endtask : run_forcing

	initial begin
		rst_n = 1'b0;
		n_mismatch = 0;
		tests_run = 0;
		cycles = 0;
		rd_m = 1'b0;
		hold_reset(16);
		release_sync();
		run_alternation();
		run_forcing();
		hold_reset(3);
		release_sync();
		run_alternation();
		report_and_stop();
	end

endmodule : line_encoder_reset_disparity_tb
`default_nettype wire
